// ### inc/dbg_port_pkg.sv
// Shared constants and state encoding of the debug request and acknowledge port
package dbg_port_pkg;

  // ****************************************
  // Word layout
  // ****************************************
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 24;
  localparam int SEL_BITS = 5;
  localparam int WORD_BITS = SEL_BITS + DATA_BITS;
  localparam int CMD_RD_POS = 7;
  localparam int CMD_GO_POS = 6;

  // ****************************************
  // Timing counts in core clock cycles
  // ****************************************
  localparam int ACK_CYCLES = 4;
  localparam int SETTLE_CYCLES = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic SERIAL_IDLE = 1'b1;
  localparam logic REQ_IDLE = 1'b1;

  // ****************************************
  // Controller states, Gray coded along the usual path
  // ****************************************
  typedef enum logic [3:0] {
    ST_BOOT      = 4'h0,
    ST_RUN       = 4'h1,
    ST_HALT      = 4'h3,
    ST_ENTER_ACK = 4'h2,
    ST_REL_WAIT  = 4'h6,
    ST_CMD       = 4'h7,
    ST_RD_WAIT   = 4'h5,
    ST_RD_ACK    = 4'h4,
    ST_RD_SHIFT  = 4'hC,
    ST_RD_END    = 4'hD,
    ST_WR_ACK    = 4'hF,
    ST_WR_DATA   = 4'hE,
    ST_WR_STORE  = 4'hA,
    ST_WR_ACK2   = 4'hB,
    ST_RST_ACK   = 4'h9
  } state_t;

endpackage : dbg_port_pkg

// ### inc/word_buf_if.sv
// Valid and ready carrier between the serial controller and the write buffer
`timescale 1ns/10ps
`default_nettype none
interface word_buf_if #(parameter int W = 29);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic empty;

  modport src (output in_valid, output in_data, input in_ready, input empty);
  modport store (input in_valid, input in_data, output in_ready, output out_valid,
                 output out_data, output empty, input out_ready);
  modport sink (input out_valid, input out_data, output out_ready);
endinterface : word_buf_if
`default_nettype wire

// ### design/word_buffer.sv
// Two-entry write buffer with registered valid and ready, empty decoded from the valid flops
`timescale 1ns/10ps
`default_nettype none
module word_buffer #(
  parameter int W = 29
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  word_buf_if.store bus
);

  logic [W-1:0] mem_r [2];
  logic [W-1:0] mem_nxt [2];
  logic [1:0] vld_r;
  logic [1:0] vld_nxt;
  logic pop;
  logic push;

  // Slot 0 is the head; slot 1 only fills while the head is stalled
  always_comb begin
    pop = vld_r[0] & bus.out_ready;
    push = bus.in_valid & ~vld_r[1];
    mem_nxt = mem_r;
    vld_nxt = vld_r;
    if (pop) begin
      mem_nxt[0] = mem_r[1];
      vld_nxt[0] = vld_r[1];
      vld_nxt[1] = 1'b0;
    end
    if (push) begin
      if (!vld_nxt[0]) begin
        mem_nxt[0] = bus.in_data;
        vld_nxt[0] = 1'b1;
      end else begin
        mem_nxt[1] = bus.in_data;
        vld_nxt[1] = 1'b1;
      end
    end
  end

  // Storage and flags
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vld_r <= 2'h0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      vld_r <= vld_nxt;
      mem_r <= mem_nxt;
    end
  end

  // Valid and data are flop slices; ready is an inverted flop and empty is decoded from both valid flops
  assign bus.out_valid = vld_r[0];
  assign bus.out_data = mem_r[0];
  assign bus.in_ready = ~vld_r[1];
  assign bus.empty = (vld_r == 2'h0);

  no_overflow_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    vld_r[1] |-> vld_r[0])
    else $error("buffer second slot filled without a head");

endmodule : word_buffer
`default_nettype wire

// ### design/debug_request_ack_port.sv
// Debug request, serial output and acknowledge controller of the emulation port
`timescale 1ns/10ps
`default_nettype none
module debug_request_ack_port (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic DEBUG_REQUEST_N_IN,
  input wire logic DEBUG_SHIFT_CLOCK_IN,
  input wire logic CHIP_STATUS_BIT0_IN,
  input wire logic [1:0] CORE_STATUS_IN,
  input wire logic INSTR_DONE_IN,
  input wire logic CORE_LOW_POWER_IN,
  input wire logic REG_RD_VALID_IN,
  input wire logic [dbg_port_pkg::DATA_BITS-1:0] REG_RDATA_IN,
  input wire logic REG_WR_READY_IN,
  output logic DEBUG_SERIAL_OUT_OUT,
  output logic CHIP_STATUS_BIT0_OUT,
  output logic CHIP_STATUS_BIT0_OE_N_OUT,
  output logic CHIP_STATUS_BIT1_OUT,
  output logic CORE_HALT_OUT,
  output logic PIPE_SAVE_OUT,
  output logic CORE_WAKE_OUT,
  output logic DEBUG_MODE_OUT,
  output logic [dbg_port_pkg::SEL_BITS-1:0] REG_SEL_OUT,
  output logic REG_RD_OUT,
  output logic REG_WR_OUT,
  output logic [dbg_port_pkg::SEL_BITS-1:0] REG_WR_SEL_OUT,
  output logic [dbg_port_pkg::DATA_BITS-1:0] REG_WR_DATA_OUT
);

  localparam int DB = dbg_port_pkg::DATA_BITS;
  localparam int CB = dbg_port_pkg::CMD_BITS;

  // ****************************************
  // State decoding helpers
  // ****************************************
  function automatic logic is_ack(input dbg_port_pkg::state_t s);
    is_ack = (s == dbg_port_pkg::ST_ENTER_ACK) || (s == dbg_port_pkg::ST_RST_ACK) ||
             (s == dbg_port_pkg::ST_RD_ACK) || (s == dbg_port_pkg::ST_WR_ACK) ||
             (s == dbg_port_pkg::ST_WR_ACK2);
  endfunction : is_ack

  // Command session states, where a fresh request means a controller reset
  function automatic logic in_session(input dbg_port_pkg::state_t s);
    in_session = (s == dbg_port_pkg::ST_CMD) || (s == dbg_port_pkg::ST_RD_WAIT) ||
                 (s == dbg_port_pkg::ST_RD_ACK) || (s == dbg_port_pkg::ST_RD_SHIFT) ||
                 (s == dbg_port_pkg::ST_RD_END) || (s == dbg_port_pkg::ST_WR_ACK) ||
                 (s == dbg_port_pkg::ST_WR_DATA) || (s == dbg_port_pkg::ST_WR_STORE) ||
                 (s == dbg_port_pkg::ST_WR_ACK2);
  endfunction : in_session

  // ****************************************
  // Registers
  // ****************************************
  dbg_port_pkg::state_t state_r, state_nxt;
  logic sck_s1_r, sck_s2_r, sck_s3_r;
  logic dsi_s1_r, dsi_s2_r;
  logic req_s1_r, req_s2_r, req_s3_r;
  logic [DB-1:0] shreg_r, shreg_nxt;
  logic [CB-1:0] cmd_r, cmd_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic dso_r, dso_nxt;
  logic halt_r, halt_nxt;
  logic save_r, save_nxt;
  logic wake_r, wake_nxt;
  logic dbg_r, dbg_nxt;
  logic rd_r, rd_nxt;
  logic push_r, push_nxt;
  logic st0_r, st0_nxt;
  logic st0_oe_n_r, st0_oe_n_nxt;
  logic st1_r, st1_nxt;
  logic sck_rise, sck_fall, req_on, req_fell, leave;

  word_buf_if #(.W(dbg_port_pkg::WORD_BITS)) wbus ();

  // Edges seen on synchronised copies; one-eighth rate leaves time for each
  assign sck_rise = sck_s2_r & ~sck_s3_r;
  assign sck_fall = ~sck_s2_r & sck_s3_r;
  assign req_on = ~req_s2_r;
  assign req_fell = ~req_s2_r & req_s3_r;

  // ****************************************
  // Controller next state
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    shreg_nxt = shreg_r;
    cmd_nxt = cmd_r;
    bit_nxt = bit_r;
    cnt_nxt = cnt_r;
    dso_nxt = dso_r;
    halt_nxt = halt_r;
    dbg_nxt = dbg_r;
    save_nxt = 1'b0;
    wake_nxt = 1'b0;
    rd_nxt = 1'b0;
    leave = 1'b0;
    push_nxt = push_r;
    if (push_r && wbus.in_ready) begin
      push_nxt = 1'b0;
    end
    // Wake a sleeping core on a fresh request
    if (req_fell && !dbg_r && CORE_LOW_POWER_IN) begin
      wake_nxt = 1'b1;
    end
    case (state_r)
      dbg_port_pkg::ST_BOOT: begin
        // Core held until the synchronised request has settled
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == 3'(dbg_port_pkg::SETTLE_CYCLES - 1)) begin
          cnt_nxt = 3'h0;
          if (req_on) begin
            state_nxt = dbg_port_pkg::ST_ENTER_ACK;
            dbg_nxt = 1'b1;
          end else begin
            state_nxt = dbg_port_pkg::ST_RUN;
            halt_nxt = 1'b0;
          end
        end
      end
      dbg_port_pkg::ST_RUN: begin
        if (req_on) begin
          state_nxt = dbg_port_pkg::ST_HALT;
          halt_nxt = 1'b1;
        end
      end
      dbg_port_pkg::ST_HALT: begin
        // Wait for the instruction in flight to retire
        if (INSTR_DONE_IN) begin
          state_nxt = dbg_port_pkg::ST_ENTER_ACK;
          save_nxt = 1'b1;
          dbg_nxt = 1'b1;
        end
      end
      dbg_port_pkg::ST_ENTER_ACK, dbg_port_pkg::ST_RST_ACK, dbg_port_pkg::ST_RD_ACK,
      dbg_port_pkg::ST_WR_ACK, dbg_port_pkg::ST_WR_ACK2: begin
        // Fixed-width low pulse, then the line returns high
        dso_nxt = 1'b0;
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == 3'(dbg_port_pkg::ACK_CYCLES)) begin
          cnt_nxt = 3'h0;
          dso_nxt = dbg_port_pkg::SERIAL_IDLE;
          if (state_r == dbg_port_pkg::ST_RD_ACK) begin
            state_nxt = dbg_port_pkg::ST_RD_SHIFT;
          end else if (state_r == dbg_port_pkg::ST_WR_ACK) begin
            state_nxt = dbg_port_pkg::ST_WR_DATA;
          end else if (state_r == dbg_port_pkg::ST_WR_ACK2) begin
            leave = cmd_r[dbg_port_pkg::CMD_GO_POS];
            state_nxt = dbg_port_pkg::ST_CMD;
          end else begin
            state_nxt = dbg_port_pkg::ST_REL_WAIT;
          end
        end
      end
      dbg_port_pkg::ST_REL_WAIT: begin
        // No command is taken while the request is still held
        if (!req_on) begin
          state_nxt = dbg_port_pkg::ST_CMD;
          bit_nxt = 5'h0;
        end
      end
      dbg_port_pkg::ST_CMD: begin
        if (sck_fall) begin
          cmd_nxt = {cmd_r[CB-2:0], dsi_s2_r};
          bit_nxt = bit_r + 5'h1;
          if (bit_r == 5'(CB - 1)) begin
            bit_nxt = 5'h0;
            if (cmd_nxt[dbg_port_pkg::CMD_RD_POS]) begin
              state_nxt = dbg_port_pkg::ST_RD_WAIT;
              rd_nxt = 1'b1;
            end else begin
              state_nxt = dbg_port_pkg::ST_WR_ACK;
            end
          end
        end
      end
      dbg_port_pkg::ST_RD_WAIT: begin
        // Selected register contents become the outgoing word
        if (REG_RD_VALID_IN) begin
          shreg_nxt = REG_RDATA_IN;
          state_nxt = dbg_port_pkg::ST_RD_ACK;
        end
      end
      dbg_port_pkg::ST_RD_SHIFT: begin
        if (sck_rise) begin
          dso_nxt = shreg_r[DB-1];
          shreg_nxt = {shreg_r[DB-2:0], 1'b0};
          bit_nxt = bit_r + 5'h1;
          if (bit_r == 5'(DB - 1)) begin
            bit_nxt = 5'h0;
            state_nxt = dbg_port_pkg::ST_RD_END;
          end
        end
      end
      dbg_port_pkg::ST_RD_END: begin
        // Last bit stands until the host has sampled it
        if (sck_fall) begin
          dso_nxt = dbg_port_pkg::SERIAL_IDLE;
          leave = cmd_r[dbg_port_pkg::CMD_GO_POS];
          state_nxt = dbg_port_pkg::ST_CMD;
        end
      end
      dbg_port_pkg::ST_WR_DATA: begin
        if (sck_fall) begin
          shreg_nxt = {shreg_r[DB-2:0], dsi_s2_r};
          bit_nxt = bit_r + 5'h1;
          if (bit_r == 5'(DB - 1)) begin
            bit_nxt = 5'h0;
            state_nxt = dbg_port_pkg::ST_WR_STORE;
            push_nxt = 1'b1;
          end
        end
      end
      dbg_port_pkg::ST_WR_STORE: begin
        // Acknowledge only emulation_port the word has left the buffer
        if (!push_r && wbus.empty) begin
          state_nxt = dbg_port_pkg::ST_WR_ACK2;
        end
      end
      default: begin
        state_nxt = dbg_port_pkg::ST_BOOT;
      end
    endcase
    // Resume the core when the command asked for it
    if (leave) begin
      state_nxt = dbg_port_pkg::ST_RUN;
      halt_nxt = 1'b0;
      dbg_nxt = 1'b0;
    end
    // Request inside a session restarts the controller, a way out of lost sync
    if (req_fell && in_session(state_r)) begin
      state_nxt = dbg_port_pkg::ST_RST_ACK;
      cnt_nxt = 3'h0;
      bit_nxt = 5'h0;
    end
    // Status bit0 released and bit1 driven low while the port is in debug mode
    st0_nxt = dbg_nxt ? 1'b0 : CORE_STATUS_IN[0];
    st1_nxt = dbg_nxt ? 1'b0 : CORE_STATUS_IN[1];
    st0_oe_n_nxt = dbg_nxt;
  end

  // ****************************************
  // Register update and input synchronisers
  // ****************************************
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= dbg_port_pkg::ST_BOOT;
      {sck_s1_r, sck_s2_r, sck_s3_r} <= 3'h0;
      {dsi_s1_r, dsi_s2_r} <= 2'h0;
      {req_s1_r, req_s2_r, req_s3_r} <= {3{dbg_port_pkg::REQ_IDLE}};
      shreg_r <= '0;
      cmd_r <= '0;
      bit_r <= 5'h0;
      cnt_r <= 3'h0;
      dso_r <= dbg_port_pkg::SERIAL_IDLE;
      halt_r <= 1'b1;
      save_r <= 1'b0;
      wake_r <= 1'b0;
      dbg_r <= 1'b0;
      rd_r <= 1'b0;
      push_r <= 1'b0;
      st0_r <= 1'b0;
      st0_oe_n_r <= 1'b0;
      st1_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      {sck_s1_r, sck_s2_r, sck_s3_r} <= {DEBUG_SHIFT_CLOCK_IN, sck_s1_r, sck_s2_r};
      {dsi_s1_r, dsi_s2_r} <= {CHIP_STATUS_BIT0_IN, dsi_s1_r};
      {req_s1_r, req_s2_r, req_s3_r} <= {DEBUG_REQUEST_N_IN, req_s1_r, req_s2_r};
      shreg_r <= shreg_nxt;
      cmd_r <= cmd_nxt;
      bit_r <= bit_nxt;
      cnt_r <= cnt_nxt;
      dso_r <= dso_nxt;
      halt_r <= halt_nxt;
      save_r <= save_nxt;
      wake_r <= wake_nxt;
      dbg_r <= dbg_nxt;
      rd_r <= rd_nxt;
      push_r <= push_nxt;
      st0_r <= st0_nxt;
      st0_oe_n_r <= st0_oe_n_nxt;
      st1_r <= st1_nxt;
    end
  end

  // ****************************************
  // Write buffer, stalled by the register side
  // ****************************************
  assign wbus.in_valid = push_r;
  assign wbus.in_data = {cmd_r[dbg_port_pkg::SEL_BITS-1:0], shreg_r};
  assign wbus.out_ready = REG_WR_READY_IN;

  word_buffer #(.W(dbg_port_pkg::WORD_BITS)) u_wbuf (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .bus(wbus.store)
  );

  // Outputs, each a flop
  assign DEBUG_SERIAL_OUT_OUT = dso_r;
  assign CHIP_STATUS_BIT0_OUT = st0_r;
  assign CHIP_STATUS_BIT0_OE_N_OUT = st0_oe_n_r;
  assign CHIP_STATUS_BIT1_OUT = st1_r;
  assign CORE_HALT_OUT = halt_r;
  assign PIPE_SAVE_OUT = save_r;
  assign CORE_WAKE_OUT = wake_r;
  assign DEBUG_MODE_OUT = dbg_r;
  assign REG_SEL_OUT = cmd_r[dbg_port_pkg::SEL_BITS-1:0];
  assign REG_RD_OUT = rd_r;
  assign REG_WR_OUT = wbus.out_valid;
  assign REG_WR_SEL_OUT = wbus.out_data[dbg_port_pkg::WORD_BITS-1:DB];
  assign REG_WR_DATA_OUT = wbus.out_data[DB-1:0];

  // ****************************************
  // Assertions and covers
  // ****************************************
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  ack_width_a : assert property ($fell(dso_r) && is_ack(state_r) |->
    !dso_r[*4] ##1 dso_r)
    else $error("acknowledge pulse width wrong");
  enter_halt_a : assert property (state_r == dbg_port_pkg::ST_HALT && INSTR_DONE_IN |=>
    PIPE_SAVE_OUT && DEBUG_MODE_OUT && CORE_HALT_OUT)
    else $error("debug entry at boundary failed");
  enter_pulse_a : assert property ($rose(state_r == dbg_port_pkg::ST_ENTER_ACK) |->
    ##1 !dso_r)
    else $error("no acknowledge on debug entry");
  msb_out_a : assert property (state_r == dbg_port_pkg::ST_RD_SHIFT && sck_rise |=>
    dso_r == $past(shreg_r[DB-1]))
    else $error("serial output not msb first");
  out_stable_a : assert property (state_r == dbg_port_pkg::ST_RD_SHIFT && !sck_rise
    && !req_fell |=> $stable(dso_r))
    else $error("serial output moved without rising edge");
  rd_load_a : assert property (state_r == dbg_port_pkg::ST_RD_WAIT && REG_RD_VALID_IN
    && !req_fell |=> shreg_r == $past(REG_RDATA_IN) ##1 !dso_r)
    else $error("read data not loaded or not acknowledged");
  wr_ack_a : assert property (state_r == dbg_port_pkg::ST_CMD && sck_fall && !req_fell
    && bit_r == 5'(CB - 1) && !cmd_r[CB-2] |=> state_r == dbg_port_pkg::ST_WR_ACK)
    else $error("write command not acknowledged");
  wr_done_a : assert property (state_r == dbg_port_pkg::ST_WR_STORE && !push_r
    && wbus.empty && !req_fell |=> state_r == dbg_port_pkg::ST_WR_ACK2 ##1 !dso_r)
    else $error("stored write not acknowledged");
  in_capture_a : assert property (state_r == dbg_port_pkg::ST_CMD && sck_fall |=>
    cmd_r[0] == $past(dsi_s2_r))
    else $error("input bit not captured on falling edge");
  ctl_reset_a : assert property (req_fell && in_session(state_r) |=>
    state_r == dbg_port_pkg::ST_RST_ACK ##1 !dso_r)
    else $error("request did not reset controller");
  wake_a : assert property (req_fell && !dbg_r && CORE_LOW_POWER_IN |=> CORE_WAKE_OUT)
    else $error("request did not wake core");
  boot_debug_a : assert property (state_r == dbg_port_pkg::ST_BOOT && req_on &&
    cnt_r == 3'(dbg_port_pkg::SETTLE_CYCLES - 1) |=> DEBUG_MODE_OUT && CORE_HALT_OUT)
    else $error("request at reset release missed");
  status_a : assert property (!dbg_nxt |=> CHIP_STATUS_BIT1_OUT == $past(CORE_STATUS_IN[1])
    && !CHIP_STATUS_BIT0_OE_N_OUT)
    else $error("status pins not reporting core status");

  read_done_c : cover property (state_r == dbg_port_pkg::ST_RD_END && sck_fall);
  write_done_c : cover property (state_r == dbg_port_pkg::ST_WR_ACK2 && dso_r);
  buf_stall_c : cover property (!wbus.in_ready && push_r);
  resync_c : cover property (state_r == dbg_port_pkg::ST_RST_ACK);

endmodule : debug_request_ack_port
`default_nettype wire

// ### tb/debug_host_model.sv
// Behavioural model of the external debug command controller
`timescale 1ns/10ps
`default_nettype none
module debug_host_model (
  input wire logic clk_in,
  input wire logic serial_in,
  output logic req_n_out,
  output logic sclk_out,
  output logic si_out,
  output logic si_en_out
);
  // ****************************************
  // Link idle and link tasks
  // ****************************************
  // Shift clock stands low between frames, data line left to its pull-down
  initial begin
    req_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b0;
    si_en_out = 1'b0;
  end

  // Request level, moved off the core clock edge
  task automatic set_req(input logic lvl);
    @(posedge clk_in);
    #7;
    req_n_out = lvl;
  endtask : set_req

  // Half period of 100 ns keeps the shift clock at 1/8 of the core clock
  task automatic shift_word(input logic [31:0] w, input int n, input logic drive,
                            output logic [31:0] got);
    got = '0;
    @(posedge clk_in);
    #9;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_out = 1'b1;
      si_out = w[i];
      si_en_out = drive;
      #96;
      got = {got[30:0], serial_in};
      #4;
      sclk_out = 1'b0;
      // No trailing low half after the last bit, so a prompt acknowledge is not missed
      if (i > 0) begin
        #100;
      end
    end
    #60;
    si_en_out = 1'b0;
  endtask : shift_word
endmodule : debug_host_model
`default_nettype wire

// ### tb/debug_request_ack_port_test.sv
// Self-checking testbench of the debug request and acknowledge port
`timescale 1ns/10ps
`default_nettype none
module debug_request_ack_port_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] core_status = 2'b10;
  logic instr_done = 1'b0;
  logic low_power = 1'b0;
  logic rd_valid = 1'b0;
  logic [23:0] rdata = '0;
  logic wr_ready = 1'b0;
  logic req_n, sclk, si, si_en, so, st0_wire, st0_out, st0_oe_n, st1;
  logic halt, psave, wake, dmode, rd, wr;
  logic [4:0] sel, wr_sel;
  logic [23:0] wr_data;
  int error_cnt = 0;
  int tests_run = 0;

  // Pull-down on the shared pin; the device drives it while oe_n is low
  assign st0_wire = !st0_oe_n ? st0_out : (si_en ? si : 1'b0);
  always #12.5 clk = ~clk;

  debug_request_ack_port debug_request_ack_port_i (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .DEBUG_REQUEST_N_IN(req_n),
    .DEBUG_SHIFT_CLOCK_IN(sclk), .CHIP_STATUS_BIT0_IN(st0_wire),
    .CORE_STATUS_IN(core_status), .INSTR_DONE_IN(instr_done),
    .CORE_LOW_POWER_IN(low_power), .REG_RD_VALID_IN(rd_valid), .REG_RDATA_IN(rdata),
    .REG_WR_READY_IN(wr_ready), .DEBUG_SERIAL_OUT_OUT(so), .CHIP_STATUS_BIT0_OUT(st0_out),
    .CHIP_STATUS_BIT0_OE_N_OUT(st0_oe_n), .CHIP_STATUS_BIT1_OUT(st1),
    .CORE_HALT_OUT(halt), .PIPE_SAVE_OUT(psave), .CORE_WAKE_OUT(wake),
    .DEBUG_MODE_OUT(dmode), .REG_SEL_OUT(sel), .REG_RD_OUT(rd), .REG_WR_OUT(wr),
    .REG_WR_SEL_OUT(wr_sel), .REG_WR_DATA_OUT(wr_data)
  );

  debug_host_model debug_host_model_i (
    .clk_in(clk), .serial_in(so), .req_n_out(req_n), .sclk_out(sclk),
    .si_out(si), .si_en_out(si_en)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Bounded wait for a level on one output; running out ends the run
  task automatic wait_for(input int which, input logic lvl);
    logic v;
    for (int n = 0; n < 400; n++) begin
      @(negedge clk);
      case (which)
        0: v = so;
        1: v = psave;
        2: v = rd;
        3: v = wr;
        default: v = wake;
      endcase
      if (v === lvl) begin
        return;
      end
    end
    check(32'h0, 32'h1, "wait ran out");
    final_report();
  endtask : wait_for

  // Length of the next low acknowledge, counted in core cycles
  task automatic ack_check();
    int len;
    len = 0;
    wait_for(0, 1'b0);
    while (so === 1'b0 && len < 20) begin
      len++;
      @(negedge clk);
    end
    check(len, dbg_port_pkg::ACK_CYCLES, "ack length");
  endtask : ack_check

  // ****************************************
  // Scenarios
  // ****************************************
  // Status pins follow a changing core status while out of debug mode
  task automatic t_status(input logic [1:0] cs);
    @(posedge clk);
    core_status <= cs;
    repeat (6) @(negedge clk);
    check(st0_oe_n, 1'b0, "bit0 driven");
    check({st1, st0_out}, cs, "status pins");
    check(halt, 1'b0, "running");
    $display("Test status done");
  endtask : t_status

  // Entry waits for the instruction boundary; optional wake from low power
  task automatic t_enter(input logic lp);
    @(posedge clk);
    low_power <= lp;
    debug_host_model_i.set_req(1'b0);
    if (lp) begin
      wait_for(4, 1'b1);
      check(wake, 1'b1, "wake pulse");
    end
    repeat (12) @(negedge clk);
    check(halt, 1'b1, "halt held");
    check(dmode, 1'b0, "no debug before boundary");
    @(posedge clk);
    instr_done <= 1'b1;
    low_power <= 1'b0;
    wait_for(1, 1'b1);
    check(dmode, 1'b1, "debug with save");
    check({st0_oe_n, st1}, 2'b10, "status pins in debug");
    ack_check();
    debug_host_model_i.set_req(1'b1);
    @(posedge clk);
    instr_done <= 1'b0;
    $display("Test enter done");
  endtask : t_enter

  task automatic t_read(input logic [7:0] cmd, input logic [23:0] d);
    logic [31:0] got;
    debug_host_model_i.shift_word({24'h0, cmd}, 8, 1'b1, got);
    wait_for(2, 1'b1);
    check(sel, cmd[4:0], "read select");
    @(posedge clk);
    rd_valid <= 1'b1;
    rdata <= d;
    @(posedge clk);
    rd_valid <= 1'b0;
    ack_check();
    debug_host_model_i.shift_word(32'h0, 24, 1'b0, got);
    check(got, {8'h0, d}, "read word");
    repeat (4) @(negedge clk);
    check(so, 1'b1, "line high after word");
    check(dmode, !cmd[6], "mode after read");
    $display("Test read done");
  endtask : t_read

  // Register side stalls so the word waits in the buffer
  task automatic t_write(input logic [7:0] cmd, input logic [23:0] d);
    logic [31:0] got;
    debug_host_model_i.shift_word({24'h0, cmd}, 8, 1'b1, got);
    ack_check();
    debug_host_model_i.shift_word({8'h0, d}, 24, 1'b1, got);
    wait_for(3, 1'b1);
    check({wr_sel, wr_data}, {cmd[4:0], d}, "write word");
    repeat (10) @(negedge clk);
    check({wr, so}, 2'b11, "held, no early ack");
    @(posedge clk);
    wr_ready <= 1'b1;
    wait_for(3, 1'b0);
    @(posedge clk);
    wr_ready <= 1'b0;
    ack_check();
    $display("Test write done");
  endtask : t_write

  // Request in mid-command drops the partial word
  task automatic t_abort();
    logic [31:0] got;
    debug_host_model_i.shift_word(32'h5, 3, 1'b1, got);
    debug_host_model_i.set_req(1'b0);
    ack_check();
    debug_host_model_i.set_req(1'b1);
    check(dmode, 1'b1, "still in debug");
    $display("Test abort done");
  endtask : t_abort

  // Second reset released with the request held low
  task automatic t_boot_req();
    @(posedge clk);
    rst_n <= 1'b0;
    debug_host_model_i.set_req(1'b0);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    ack_check();
    check(dmode, 1'b1, "debug from reset");
    debug_host_model_i.set_req(1'b1);
    $display("Test boot request done");
  endtask : t_boot_req

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    check({so, halt, dmode}, 3'b110, "reset values");
    rst_n <= 1'b1;
    t_status(2'h1);
    t_enter(1'b0);
    t_read(8'h85, 24'hA5C3F1);
    t_abort();
    t_write(8'h12, 24'h5A3C96);
    t_read(8'hC9, 24'h3C0FF1);
    t_status(2'h2);
    t_enter(1'b1);
    t_boot_req();
    final_report();
  end
endmodule : debug_request_ack_port_test
`default_nettype wire
